/* crg_pkg.sv */
/*
 * Shared constants and types of the card reader general register bank.
 * Assumes a single 100 MHz clock and a word-wide Wishbone slave port.
 */
package crg_pkg;

	// Timing
	localparam int CLK_NS = 10;
	localparam int POR_TIME_NS = 160;
	localparam int POR_CYC = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0] POR_LOAD = 5'(POR_CYC);

	// Register indices, byte address is four times the index
	localparam logic [3:0] IDX_CARD_UART_RESET_CONTROL = 4'h0;
	localparam logic [3:0] IDX_CARD_POWER_CONTROL = 4'h2;
	localparam logic [3:0] IDX_FIFO_CONTROL = 4'h3;
	localparam logic [3:0] IDX_UART_STATUS = 4'h4;
	localparam logic [3:0] IDX_MIXED_STATUS = 4'h5;
	localparam logic [3:0] IDX_UART_MASK = 4'h6;
	localparam logic [3:0] IDX_TIMEOUT_CONFIG = 4'h8;
	localparam logic [3:0] IDX_TIMEOUT_VALUE_LOW = 4'h9;
	localparam logic [3:0] IDX_TIMEOUT_VALUE_MID = 4'ha;
	localparam logic [3:0] IDX_TIMEOUT_VALUE_HIGH = 4'hb;
	localparam logic [3:0] IDX_HARDWARE_FAULT_STATUS = 4'hf;

	// Fields and reset values
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [7:0] CSR_WMASK = 8'h08;
	localparam int UART_RESET_N_BIT = 3;
	localparam logic [7:0] FCR_WMASK = 8'h0f;
	localparam int FCR_RETX_BIT = 3;
	localparam logic [7:0] TOC_WMASK = 8'h1f;
	localparam logic [3:0] LAT_RESET = 4'h4;
	localparam int LAT_CARD_FAULT = 3;
	localparam int LAT_SUPERVISOR = 2;
	localparam int LAT_PRESENCE = 1;
	localparam int LAT_OVERHEAT = 0;
	localparam logic [6:0] SYNC_RESET = 7'h41;

	// Time-out channel start modes
	localparam logic [1:0] TMODE_STOP = 2'h0;
	localparam logic [1:0] TMODE_ON_WRITE = 2'h1;
	localparam logic [1:0] TMODE_ON_START = 2'h2;
	localparam logic [1:0] TMODE_RELOAD = 2'h3;

	typedef struct packed {
		logic card_io;
		logic card_presence;
		logic supply_drop;
		logic overheat;
		logic rst_prot;
		logic supply_prot;
		logic shutdown_pin_n;
	} crg_pins_t;

	typedef struct packed {
		logic split;
		logic [1:0] mode_b;
		logic [1:0] mode_a;
	} crg_tmr_cfg_t;

	typedef enum logic [2:0] {
		TS_IDLE = 3'b001,
		TS_ARMED = 3'b010,
		TS_RUN = 3'b100
	} crg_tstate_t;

endpackage

/* crg_etu_timer.sv */
/*
 * ETU time-out counter: one 24-bit channel, or a 16-bit plus an 8-bit one.
 * Assumes etu_tick_i is a one-cycle pulse per elementary time unit.
 */
`timescale 1ns/10ps
module crg_etu_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Configuration
	input wire crg_pkg::crg_tmr_cfg_t cfg_i,
	input wire logic cfg_wr_i,
	input wire logic [23:0] value_i,
	// Events
	input wire logic etu_tick_i,
	input wire logic start_bit_i,
	output logic expire_o
);

	crg_pkg::crg_tstate_t st_q [2];
	logic [23:0] cnt_q [2];
	logic [1:0] exp_w;
	logic expire_q;

	function automatic logic [23:0] load_of(input logic ch,
			input crg_pkg::crg_tmr_cfg_t c, input logic [23:0] v);
		if (ch)
			return {16'h0000, v[7:0]};
		if (c.split)
			return {8'h00, v[23:8]};
		return v;
	endfunction

	function automatic logic [1:0] mode_of(input logic ch,
			input crg_pkg::crg_tmr_cfg_t c);
		if (ch)
			return c.split ? c.mode_b : crg_pkg::TMODE_STOP;
		return c.mode_a;
	endfunction

	for (genvar g = 0; g < 2; g++) begin : g_chan
		logic [23:0] load_w;
		logic [1:0] mode_w;
		logic last_w;
		assign load_w = load_of(1'(g), cfg_i, value_i);
		assign mode_w = mode_of(1'(g), cfg_i);
		assign last_w = cnt_q[g] <= 24'h000001;
		assign exp_w[g] = st_q[g] == crg_pkg::TS_RUN && etu_tick_i &&
			last_w && !cfg_wr_i;

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				st_q[g] <= crg_pkg::TS_IDLE;
				cnt_q[g] <= 24'h000000;
			end else if (cfg_wr_i) begin
				cnt_q[g] <= load_w;
				case (mode_w)
				crg_pkg::TMODE_STOP: st_q[g] <= crg_pkg::TS_IDLE;
				crg_pkg::TMODE_ON_START: st_q[g] <= crg_pkg::TS_ARMED;
				default: st_q[g] <= crg_pkg::TS_RUN;
				endcase
			end else begin
				case (st_q[g])
				crg_pkg::TS_ARMED: begin
					if (start_bit_i) begin
						st_q[g] <= crg_pkg::TS_RUN;
						cnt_q[g] <= load_w;
					end
				end
				crg_pkg::TS_RUN: begin
					if (etu_tick_i && !last_w)
						cnt_q[g] <= cnt_q[g] - 24'h000001;
					else if (etu_tick_i && mode_w == crg_pkg::TMODE_RELOAD)
						cnt_q[g] <= load_w;
					else if (etu_tick_i)
						st_q[g] <= crg_pkg::TS_IDLE;
				end
				crg_pkg::TS_IDLE: st_q[g] <= crg_pkg::TS_IDLE;
				default: st_q[g] <= crg_pkg::TS_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			expire_q <= 1'b0;
		else
			expire_q <= |exp_w;
	end

	assign expire_o = expire_q;

	chk_arm_start_run: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q[0] == crg_pkg::TS_ARMED && start_bit_i && !cfg_wr_i
		|=> st_q[0] == crg_pkg::TS_RUN && cnt_q[0] == $past(g_chan[0].load_w))
		else $error("armed channel did not start on start bit");

	chk_count_down: assert property (@(posedge clk_i) disable iff (rst_i)
		st_q[0] == crg_pkg::TS_RUN && etu_tick_i && !g_chan[0].last_w &&
		!cfg_wr_i |=> cnt_q[0] == $past(cnt_q[0]) - 24'h000001)
		else $error("time-out counter did not decrement on tick");

	chk_expire_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		exp_w[0] |=> expire_o)
		else $error("expiry did not raise expire output");

endmodule // crg_etu_timer

/* crg_regs.sv */
/*
 * General control and status registers of the smart card reader front end.
 * Assumes a classic Wishbone master on clk_i and raw pins needing sync.
 */
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps

// Behaviour
// - Card select register resets to zero, holding the card UART in reset.
// - While UART reset bit is low, card UART registers are forced to init; FIFO control, UART mask and time-out here keep their values.
// - Interrupt low while fault, presence, overheat latch or shutdown bit set.
// - Status read clears the reported bits two cycles after the read.
// - Any emergency latch clears the activation start bit automatically.
// - Shutdown status bit is set while the shutdown pin is low.
// - Shut-down mode lasts until the shutdown pin returns high.
// - Mixed status raises no interrupt; tx empty/rx full is maskable.
// - FIFO control sets receive depth 1 to 8 and NAK retransmission.
// - Time-out counter counts ETUs to programmed value and then interrupts.
// - Each counter starts on write, on a start bit, or auto-reloads.
// - Card fault latch sets on supply or reset-line protection fault.
// - Supervisor latch sets at power-on, clears only on read after pulse.
// - Presence change latch sets when card presence changes.
// - Overheat latch sets whenever overheating occurs.
module crg_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins
	input wire crg_pkg::crg_pins_t pins_i,
	// Card UART side
	input wire logic tx_empty_rx_full_i,
	input wire logic etu_tick_i,
	output logic uart_soft_reset_n_o,
	output logic [2:0] fifo_depth_o,
	output logic retransmit_en_o,
	// Card power and system
	output logic card_start_o,
	output logic shutdown_mode_o,
	output logic irq_out_n_o
);

	// Pin synchronisers
	logic [6:0] s1_q;
	logic [6:0] s2_q;
	logic [6:0] s3_q;
	logic [6:0] stab_q;
	logic [6:0] stab_d;
	logic [6:0] agree_w;
	crg_pkg::crg_pins_t pin_w;
	crg_pkg::crg_pins_t chg_w;

	assign agree_w = ~(s2_q ^ s3_q);
	assign stab_d = (agree_w & s3_q) | (~agree_w & stab_q);
	assign pin_w = crg_pkg::crg_pins_t'(stab_q);
	assign chg_w = crg_pkg::crg_pins_t'(stab_d ^ stab_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= crg_pkg::SYNC_RESET;
			s2_q <= crg_pkg::SYNC_RESET;
			s3_q <= crg_pkg::SYNC_RESET;
			stab_q <= crg_pkg::SYNC_RESET;
		end else begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stab_q <= stab_d;
		end
	end

	// Bus decode
	logic acc_w;
	logic wr_w;
	logic rd_w;
	logic [3:0] idx_w;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] rdata_w;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] i);
		return a == i;
	endfunction

	assign idx_w = wb_adr_i[5:2];
	assign acc_w = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_w = acc_w && wb_we_i && wb_sel_i[0];
	assign rd_w = acc_w && !wb_we_i;

	logic wr_csr_w;
	logic wr_pcr_w;
	logic wr_fcr_w;
	logic wr_mask_w;
	logic wr_toc_w;
	logic rd_hfs_w;
	logic rd_usr_w;

	assign wr_csr_w = wr_w && hit(idx_w, crg_pkg::IDX_CARD_UART_RESET_CONTROL);
	assign wr_pcr_w = wr_w && hit(idx_w, crg_pkg::IDX_CARD_POWER_CONTROL);
	assign wr_fcr_w = wr_w && hit(idx_w, crg_pkg::IDX_FIFO_CONTROL);
	assign wr_mask_w = wr_w && hit(idx_w, crg_pkg::IDX_UART_MASK);
	assign wr_toc_w = wr_w && hit(idx_w, crg_pkg::IDX_TIMEOUT_CONFIG);
	assign rd_hfs_w = rd_w && hit(idx_w, crg_pkg::IDX_HARDWARE_FAULT_STATUS);
	assign rd_usr_w = rd_w && hit(idx_w, crg_pkg::IDX_UART_STATUS);

	// Software registers
	logic [7:0] csr_q;
	logic start_q;
	logic start_d;
	logic [7:0] fcr_q;
	logic mask_q;
	logic [7:0] toc_q;
	logic toc_wr_q;
	logic [23:0] tor_q;
	logic emerg_w;

	assign start_d = emerg_w ? 1'b0 : (wr_pcr_w ? wb_dat_i[0] : start_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			csr_q <= crg_pkg::CSR_RESET;
			start_q <= 1'b0;
			fcr_q <= 8'h00;
			mask_q <= 1'b0;
			toc_q <= 8'h00;
			toc_wr_q <= 1'b0;
			tor_q <= 24'h000000;
		end else begin
			if (wr_csr_w)
				csr_q <= wb_dat_i[7:0] & crg_pkg::CSR_WMASK;
			start_q <= start_d;
			if (wr_fcr_w)
				fcr_q <= wb_dat_i[7:0] & crg_pkg::FCR_WMASK;
			if (wr_mask_w)
				mask_q <= wb_dat_i[0];
			if (wr_toc_w)
				toc_q <= wb_dat_i[7:0] & crg_pkg::TOC_WMASK;
			toc_wr_q <= wr_toc_w;
			if (wr_w && hit(idx_w, crg_pkg::IDX_TIMEOUT_VALUE_LOW))
				tor_q[7:0] <= wb_dat_i[7:0];
			if (wr_w && hit(idx_w, crg_pkg::IDX_TIMEOUT_VALUE_MID))
				tor_q[15:8] <= wb_dat_i[7:0];
			if (wr_w && hit(idx_w, crg_pkg::IDX_TIMEOUT_VALUE_HIGH))
				tor_q[23:16] <= wb_dat_i[7:0];
		end
	end

	// Power-on pulse and status latches
	logic [4:0] por_q;
	logic por_busy_w;
	logic por_start_w;
	logic shutdown_request_exit_w;
	logic shutdown_request_low_w;
	logic [3:0] lat_q;
	logic [3:0] lat_set_w;
	logic [3:0] snap1_q;
	logic [3:0] snap2_q;
	logic [3:0] clrable_w;

	assign shutdown_request_low_w = !pin_w.shutdown_pin_n;
	assign shutdown_request_exit_w = chg_w.shutdown_pin_n && !pin_w.shutdown_pin_n;
	assign por_start_w = pin_w.supply_drop || shutdown_request_exit_w;
	assign por_busy_w = por_q != 5'h00;

	assign lat_set_w[crg_pkg::LAT_CARD_FAULT] =
		pin_w.supply_prot || pin_w.rst_prot;
	assign lat_set_w[crg_pkg::LAT_SUPERVISOR] = por_start_w;
	assign lat_set_w[crg_pkg::LAT_PRESENCE] = chg_w.card_presence;
	assign lat_set_w[crg_pkg::LAT_OVERHEAT] = pin_w.overheat;
	assign emerg_w = |lat_set_w;

	// Supervisor may only be cleared by a read outside the power-on pulse
	assign clrable_w = lat_q & {1'b1, !por_busy_w, 2'b11};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			por_q <= crg_pkg::POR_LOAD;
			lat_q <= crg_pkg::LAT_RESET;
			snap1_q <= 4'h0;
			snap2_q <= 4'h0;
		end else begin
			if (por_start_w)
				por_q <= crg_pkg::POR_LOAD;
			else if (por_busy_w)
				por_q <= por_q - 5'h01;
			snap1_q <= rd_hfs_w ? clrable_w : 4'h0;
			snap2_q <= snap1_q;
			lat_q <= (lat_q & ~(snap2_q & clrable_w)) |
				lat_set_w;
		end
	end

	// UART status and time-out
	logic tmr_exp_w;
	logic tof_q;
	logic uart_irq_w;

	crg_etu_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cfg_i(crg_pkg::crg_tmr_cfg_t'(toc_q[4:0])),
		.cfg_wr_i(toc_wr_q),
		.value_i(tor_q),
		.etu_tick_i(etu_tick_i),
		.start_bit_i(chg_w.card_io && pin_w.card_io),
		.expire_o(tmr_exp_w)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			tof_q <= 1'b0;
		else
			tof_q <= (tof_q && !rd_usr_w) || tmr_exp_w;
	end

	// Mixed status stays out of the interrupt path
	assign uart_irq_w = (tx_empty_rx_full_i && !mask_q) || tof_q;

	// Interrupt, shut-down and outputs
	logic irq_n_q;
	logic irq_n_d;
	logic shutdown_request_q;

	assign irq_n_d = !(lat_q[crg_pkg::LAT_CARD_FAULT] ||
		lat_q[crg_pkg::LAT_PRESENCE] || lat_q[crg_pkg::LAT_OVERHEAT] ||
		shutdown_request_low_w || (lat_q[crg_pkg::LAT_SUPERVISOR] && por_busy_w) ||
		uart_irq_w);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_n_q <= 1'b0;
			shutdown_request_q <= 1'b0;
		end else begin
			irq_n_q <= irq_n_d;
			shutdown_request_q <= shutdown_request_low_w;
		end
	end

	// Read mux
	always_comb begin
		case (idx_w)
		crg_pkg::IDX_CARD_UART_RESET_CONTROL: rdata_w = csr_q;
		crg_pkg::IDX_CARD_POWER_CONTROL: rdata_w = {7'h00, start_q};
		crg_pkg::IDX_FIFO_CONTROL: rdata_w = fcr_q;
		crg_pkg::IDX_UART_STATUS: rdata_w = {6'h00, tof_q, tx_empty_rx_full_i};
		crg_pkg::IDX_MIXED_STATUS:
			rdata_w = {6'h00, tx_empty_rx_full_i, pin_w.card_presence};
		crg_pkg::IDX_UART_MASK: rdata_w = {7'h00, mask_q};
		crg_pkg::IDX_TIMEOUT_CONFIG: rdata_w = toc_q;
		crg_pkg::IDX_HARDWARE_FAULT_STATUS:
			rdata_w = {shutdown_request_low_w, 1'b0, lat_q[crg_pkg::LAT_CARD_FAULT],
				lat_q[crg_pkg::LAT_SUPERVISOR], 1'b0,
				lat_q[crg_pkg::LAT_PRESENCE], 1'b0,
				lat_q[crg_pkg::LAT_OVERHEAT]};
		default: rdata_w = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= acc_w;
			if (rd_w)
				dat_q <= {24'h000000, rdata_w};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign uart_soft_reset_n_o = csr_q[crg_pkg::UART_RESET_N_BIT];
	assign fifo_depth_o = fcr_q[2:0];
	assign retransmit_en_o = fcr_q[crg_pkg::FCR_RETX_BIT];
	assign card_start_o = start_q;
	assign shutdown_mode_o = shutdown_request_q;
	assign irq_out_n_o = irq_n_q;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_hfs_read;
		rd_hfs_w;
	endsequence

	sequence s_presence_quiet;
		!lat_set_w[crg_pkg::LAT_PRESENCE] [*2];
	endsequence

	chk_reset_uart_held: assert property (
		$fell(rst_i) |-> !uart_soft_reset_n_o && csr_q == 8'h00)
		else $error("UART reset bit not low after reset");

	chk_uart_reset_write: assert property (
		wr_csr_w && !wb_dat_i[3] |=> !uart_soft_reset_n_o)
		else $error("UART reset not asserted after clearing bit");

	chk_irq_sources: assert property (
		lat_q[crg_pkg::LAT_CARD_FAULT] || lat_q[crg_pkg::LAT_PRESENCE] ||
		lat_q[crg_pkg::LAT_OVERHEAT] || shutdown_request_low_w |=> !irq_out_n_o)
		else $error("interrupt not low with a source set");

	chk_read_clear_late: assert property (
		s_hfs_read ##0 lat_q[crg_pkg::LAT_PRESENCE] ##1 s_presence_quiet
		|=> !lat_q[crg_pkg::LAT_PRESENCE])
		else $error("presence latch not cleared two cycles after read");

	chk_read_clear_early: assert property (
		s_hfs_read ##0 lat_q[crg_pkg::LAT_PRESENCE]
		|=> lat_q[crg_pkg::LAT_PRESENCE] [*2])
		else $error("presence latch cleared too early");

	chk_start_emergency: assert property (
		emerg_w |=> !card_start_o)
		else $error("start bit survived an emergency");

	chk_shutdown_enter: assert property (
		shutdown_request_low_w && rd_hfs_w |=> wb_dat_o[7] && shutdown_mode_o)
		else $error("shutdown bit not reported while pin low");

	chk_shutdown_hold: assert property (
		shutdown_request_low_w |=> shutdown_mode_o)
		else $error("shut-down mode left without pin high");

	chk_supervisor_hold: assert property (
		lat_q[crg_pkg::LAT_SUPERVISOR] && por_busy_w |=>
		lat_q[crg_pkg::LAT_SUPERVISOR] [*2])
		else $error("supervisor cleared during power-on pulse");

	chk_irq_release: assert property (
		!(|lat_q) && !shutdown_request_low_w && !uart_irq_w |=> irq_out_n_o)
		else $error("interrupt stuck low with no source");

	chk_unused_zero: assert property (
		rd_w && hit(idx_w, crg_pkg::IDX_CARD_UART_RESET_CONTROL)
		|=> (wb_dat_o & 32'hfffffff7) == 32'h00000000)
		else $error("unused select bits read non-zero");

	chk_fifo_depth: assert property (
		wr_fcr_w |=> fifo_depth_o == $past(wb_dat_i[2:0]))
		else $error("FIFO depth not taken from write");

	chk_mask_txrx: assert property (
		mask_q && !tof_q && !(|lat_q) && !shutdown_request_low_w |=> irq_out_n_o)
		else $error("masked UART status raised interrupt");

endmodule // crg_regs

/* crg_host_model.sv */
/*
 * Controller-side model: a classic Wishbone master with one transfer task.
 * Assumes a slave that answers each request with a one-cycle ack.
 */
`timescale 1ns/10ps
module crg_host_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [5:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 6'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h00000000;
	end

	// One access, held until ack is sampled high
	task automatic xfer(input logic w, input logic [3:0] idx,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= w;
		wb_adr_o <= {idx, 2'b00};
		wb_sel_o <= 4'hf;
		wb_dat_o <= {24'h000000, d};
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		q = wb_dat_i[7:0];
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o <= 1'b0;
	endtask
endmodule // crg_host_model

/* crg_regs_tb.sv */
/*
 * Self-checking bench of the general register bank: bus, pins, timer.
 * Assumes the host model as bus master and a 100 MHz clock.
 */
`timescale 1ns/10ps
module crg_regs_tb;
	logic clk_i = 1'b0;
	logic rst_i;
	logic cyc, stb, we, ack;
	logic [5:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	crg_pkg::crg_pins_t pins;
	logic txrx, etu;
	logic sreset_n, retx, start, sdm, irq_n;
	logic [2:0] depth;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [6:0] msk [4];
	logic [7:0] exp_hsr [4];
	logic [7:0] d;

	always #5 clk_i = ~clk_i;

	crg_host_model i_crg_host_model (.clk_i(clk_i), .wb_cyc_o(cyc),
		.wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
		.wb_dat_o(wdat), .wb_ack_i(ack), .wb_dat_i(rdat));

	crg_regs i_crg_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins),
		.tx_empty_rx_full_i(txrx), .etu_tick_i(etu),
		.uart_soft_reset_n_o(sreset_n), .fifo_depth_o(depth),
		.retransmit_en_o(retx), .card_start_o(start),
		.shutdown_mode_o(sdm), .irq_out_n_o(irq_n));

	task automatic results();
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		tests_run++;
		if (got !== e) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, e);
		end
	endtask

	task automatic cyc_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] v);
		logic [7:0] q;
		i_crg_host_model.xfer(1'b1, idx, v, q);
	endtask

	task automatic rd(input logic [3:0] idx, input logic [7:0] e);
		logic [7:0] q;
		i_crg_host_model.xfer(1'b0, idx, 8'h00, q);
		chk(q, e);
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_i);
			etu <= 1'b1;
			@(posedge clk_i);
			etu <= 1'b0;
		end
	endtask

	// Hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end

	initial begin
		msk = '{7'h08, 7'h02, 7'h04, 7'h20};
		exp_hsr = '{8'h01, 8'h20, 8'h20, 8'h04};
		rst_i <= 1'b1;
		pins <= crg_pkg::crg_pins_t'(7'h41);
		txrx <= 1'b0;
		etu <= 1'b0;
		cyc_n(16);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({7'h00, sreset_n}, 8'h00);
		chk({7'h00, irq_n}, 8'h00);
		rd(4'h0, 8'h00);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h08);
		wr(4'h0, 8'h00);
		#1 chk({7'h00, sreset_n}, 8'h00);
		wr(4'h0, 8'h08);
		wr(4'hf, 8'hff);
		rd(4'he, 8'h00);
		cyc_n(40);
		rd(4'hf, 8'h10);
		cyc_n(4);
		rd(4'hf, 8'h00);
		#1 chk({7'h00, irq_n}, 8'h01);
		// Fault, overheat and presence sources
		for (int i = 0; i < 4; i++) begin
			wr(4'h2, 8'h01);
			#1 chk({7'h00, start}, 8'h01);
			@(posedge clk_i);
			pins <= crg_pkg::crg_pins_t'(pins ^ msk[i]);
			cyc_n(6);
			#1 chk({7'h00, irq_n}, 8'h00);
			chk({7'h00, start}, 8'h00);
			@(posedge clk_i);
			if (i < 3) pins <= crg_pkg::crg_pins_t'(pins ^ msk[i]);
			cyc_n(6);
			rd(4'hf, exp_hsr[i]);
			@(posedge clk_i);
			#1 chk({7'h00, irq_n}, 8'h00);
			@(posedge clk_i);
			#1 chk({7'h00, irq_n}, 8'h01);
			rd(4'hf, 8'h00);
		end
		// Shut-down request
		@(posedge clk_i);
		pins.shutdown_pin_n <= 1'b0;
		cyc_n(6);
		#1 chk({7'h00, irq_n}, 8'h00);
		chk({7'h00, sdm}, 8'h01);
		rd(4'hf, 8'h80);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h00);
		rd(4'hf, 8'h80);
		#1 chk({7'h00, sdm}, 8'h01);
		@(posedge clk_i);
		pins.shutdown_pin_n <= 1'b1;
		cyc_n(40);
		#1 chk({7'h00, sdm}, 8'h00);
		rd(4'hf, 8'h10);
		cyc_n(4);
		rd(4'hf, 8'h00);
		wr(4'h0, 8'h08);
		// Polled status and mask
		wr(4'h6, 8'h01);
		@(posedge clk_i);
		txrx <= 1'b1;
		cyc_n(4);
		#1 chk({7'h00, irq_n}, 8'h01);
		rd(4'h5, 8'h03);
		wr(4'h6, 8'h00);
		cyc_n(3);
		#1 chk({7'h00, irq_n}, 8'h00);
		@(posedge clk_i);
		txrx <= 1'b0;
		cyc_n(3);
		// FIFO depth codes and retransmit
		for (int k = 0; k < 8; k++) begin
			d = 8'(k) | (k[0] ? 8'h08 : 8'h00);
			wr(4'h3, d);
			#1 chk({5'h00, depth}, 8'(k));
			chk({7'h00, retx}, {7'h00, d[3]});
			rd(4'h3, d);
		end
		// Time-out start modes
		wr(4'h9, 8'h03);
		wr(4'ha, 8'h00);
		wr(4'hb, 8'h00);
		for (int m = 1; m < 5; m++) begin
			wr(4'h8, 8'h00);
			wr(4'h8, m == 4 ? 8'h14 : 8'(m));
			if (m == 2) begin
				@(posedge clk_i);
				pins.card_io <= 1'b0;
				cyc_n(6);
				pins.card_io <= 1'b1;
				cyc_n(6);
			end
			tick(5);
			cyc_n(4);
			#1 chk({7'h00, irq_n}, 8'h00);
			rd(4'h4, 8'h02);
			wr(4'h8, 8'h00);
			tick(5);
			rd(4'h4, 8'h00);
		end
		// Power-up with the shutdown pin already low
		@(posedge clk_i);
		rst_i <= 1'b1;
		pins <= crg_pkg::crg_pins_t'(7'h40);
		cyc_n(16);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({7'h00, sreset_n}, 8'h00);
		chk({7'h00, irq_n}, 8'h00);
		cyc_n(6);
		#1 chk({7'h00, sdm}, 8'h01);
		rd(4'hf, 8'h90);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h00);
		rd(4'hf, 8'h90);
		#1 chk({7'h00, irq_n}, 8'h00);
		@(posedge clk_i);
		pins.shutdown_pin_n <= 1'b1;
		cyc_n(40);
		#1 chk({7'h00, sdm}, 8'h00);
		rd(4'hf, 8'h10);
		cyc_n(4);
		rd(4'hf, 8'h00);
		#1 chk({7'h00, irq_n}, 8'h01);
		results();
	end
endmodule // crg_regs_tb
